// ===== hdl/cbr_bank.sv
// configuration byte storage with masked writes and power-down clearing
`timescale 1ns/100ps
module cbr_bank (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [7:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_idx,
   output logic [7:0] rd_data,
   input wire logic pwr_down,
   output logic [7:0] freq_byte,
   output logic [7:0] len_byte,
   output logic [7:0] fbimp_byte,
   output logic [7:0] oimp_byte
);
   import cbr_pkg::*;

   typedef struct packed {
      logic [7:0] freq;
      logic [7:0] part;
      logic [7:0] len;
      logic [7:0] pd;
      logic [7:0] fbimp;
      logic [7:0] oimp;
   } cbr_bank_type;

   cbr_bank_type r;
   cbr_bank_type nxt;

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                         input logic [7:0] mask);
      merge = (old & ~mask) | (val & mask);
   endfunction

   always_comb begin
      nxt = r;
      if (wr_en) begin
         case (wr_idx)
            IDX_FREQ: nxt.freq = merge(r.freq, wr_data, WMASK_FREQ);
            IDX_PART: nxt.part = merge(r.part, wr_data, WMASK_PART);
            IDX_LEN: nxt.len = merge(r.len, wr_data, WMASK_LEN);
            IDX_PD: nxt.pd = merge(r.pd, wr_data, WMASK_PD);
            IDX_FBIMP: nxt.fbimp = merge(r.fbimp, wr_data, WMASK_FBIMP);
            IDX_OIMP: nxt.oimp = merge(r.oimp, wr_data, WMASK_OIMP);
            default: nxt = r;
         endcase
      end
      // power-down outranks a write in the same cycle
      if (pwr_down && !r.pd[KEEP_BIT]) begin
         nxt.freq = RST_FREQ;
         nxt.part = RST_PART;
         nxt.len = RST_LEN;
         nxt.fbimp = RST_FBIMP;
         nxt.oimp = RST_OIMP;
         nxt.pd = RST_PD;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{RST_FREQ, RST_PART, RST_LEN, RST_PD, RST_FBIMP, RST_OIMP};
      end else begin
         r <= nxt;
      end
   end

   always_comb begin
      case (rd_idx)
         IDX_FREQ: rd_data = r.freq;
         IDX_REVMAK: rd_data = {REV_CODE, MAKER_CODE};
         IDX_PART: rd_data = r.part;
         IDX_LEN: rd_data = r.len;
         IDX_PD: rd_data = r.pd;
         IDX_FBIMP: rd_data = r.fbimp;
         IDX_OIMP: rd_data = r.oimp;
         default: rd_data = RSVD_READ;
      endcase
   end

   assign freq_byte = r.freq;
   assign len_byte = r.len;
   assign fbimp_byte = r.fbimp;
   assign oimp_byte = r.oimp;
endmodule

// ===== hdl/cbr_top.sv
// serial management slave and configuration outputs for bytes 3 to 12
`timescale 1ns/100ps
// Function
// - frequency enable bit resets 0; while 0, code writes leave frequency alone
// - enabled code 00/01/10 picks 100/50/125 MHz, 11 reserved, resets 00
// - feedback slew select, 0 slow 1 fast, resets to fast
// - revision and maker byte is fixed and ignores writes
// - part type and identifier byte, writable, resets to factory values
// - five-bit block read length, resets to eight, upper bits reserved zero
// - reserved bytes four, eight and nine affect nothing
// - keep bit chooses clearing or keeping configuration through power-down
// - feedback impedance code 33/85/100 ohm, reserved, variant reset
// - disabled differential output state field, resets low/low
// - four two-bit impedance codes for outputs three down to zero
// - cleared enable bit forces output into selected disabled state
// - block read returns length byte then consecutive bytes; host ends with nack
module cbr_top (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic pwr_down,
   input wire logic [cbr_pkg::NUM_OUT-1:0] out_enable_bits,
   input wire logic [cbr_pkg::NUM_OUT-1:0] oe_pin_active,
   output logic [1:0] operating_freq,
   output logic feedback_edge_speed_select,
   output logic [1:0] feedback_impedance_code,
   output logic [7:0] output_impedance_codes,
   output logic [cbr_pkg::NUM_OUT-1:0] dif_running,
   output logic [cbr_pkg::NUM_OUT-1:0] dif_true_high,
   output logic [cbr_pkg::NUM_OUT-1:0] dif_comp_high,
   output logic [cbr_pkg::NUM_OUT-1:0] dif_hiz
);
   import cbr_pkg::*;

   typedef struct packed {
      cbr_state_type state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] idx;
      logic rw;
      logic [7:0] wr_left;
      logic acked;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic sda_out;
      logic [1:0] freq_op;
      logic slew;
      logic [1:0] fbimp;
      logic [7:0] oimp;
      logic [NUM_OUT-1:0] run;
      logic [NUM_OUT-1:0] tl;
      logic [NUM_OUT-1:0] cl;
      logic [NUM_OUT-1:0] hz;
   } cbr_top_type;

   cbr_top_type r;
   cbr_top_type s;

   logic bank_we;
   logic [7:0] rd_data;
   logic [7:0] freq_byte;
   logic [7:0] len_byte;
   logic [7:0] fbimp_byte;
   logic [7:0] oimp_byte;
   logic [1:0] dstate;
   logic [NUM_OUT-1:0] run_w;
   logic [NUM_OUT-1:0] tl_w;
   logic [NUM_OUT-1:0] cl_w;
   logic [NUM_OUT-1:0] hz_w;
   logic rise;
   logic fall;
   logic start_cond;
   logic stop_cond;

   cbr_bank u_bank (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .wr_en(bank_we),
      .wr_idx(r.idx),
      .wr_data(r.shift),
      .rd_idx(r.idx),
      .rd_data(rd_data),
      .pwr_down(pwr_down),
      .freq_byte(freq_byte),
      .len_byte(len_byte),
      .fbimp_byte(fbimp_byte),
      .oimp_byte(oimp_byte)
   );

   // bus edges and framing conditions from the previous sample
   assign rise = scl_in & ~r.scl_q;
   assign fall = ~scl_in & r.scl_q;
   assign start_cond = scl_in & r.scl_q & r.sda_q & ~sda_in;
   assign stop_cond = scl_in & r.scl_q & ~r.sda_q & sda_in;

   // a data byte is stored on the falling edge that closes its eighth bit
   assign bank_we = (r.state == ST_WDATA) && fall && (r.bit_cnt == BITS_PER_BYTE)
                    && (r.wr_left != 8'h00) && !start_cond && !stop_cond;

   assign dstate = fbimp_byte[DSTATE_LSB+1:DSTATE_LSB];

   // per-output override of the enable pin by the enable bit
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
         assign run_w[gi] = out_enable_bits[gi] & oe_pin_active[gi];
         assign tl_w[gi] = ~run_w[gi] & (dstate == DS_HIGHLOW);
         assign cl_w[gi] = ~run_w[gi] & (dstate == DS_LOWHIGH);
         assign hz_w[gi] = ~run_w[gi] & (dstate == DS_HIZ);
      end
   endgenerate

   always_comb begin
      s = r;
      s.scl_q = scl_in;
      s.sda_q = sda_in;
      s.sda_out = 1'b0;

      // a new code reaches the outputs only while the enable bit is set
      if (freq_byte[FREQ_EN_BIT] &&
          freq_byte[FREQ_CODE_LSB+1:FREQ_CODE_LSB] != FREQ_RSVD) begin
         s.freq_op = freq_byte[FREQ_CODE_LSB+1:FREQ_CODE_LSB];
      end
      s.slew = freq_byte[SLEW_BIT];
      s.fbimp = fbimp_byte[FBIMP_LSB+1:FBIMP_LSB];
      s.oimp = oimp_byte;
      s.run = run_w;
      s.tl = tl_w;
      s.cl = cl_w;
      s.hz = hz_w;

      case (r.state)
         ST_IDLE: begin
            s.sda_oe = 1'b0;
         end
         ST_ADDR, ST_CMD, ST_CNT, ST_WDATA: begin
            if (rise) begin
               s.shift = {r.shift[6:0], sda_in};
               s.bit_cnt = r.bit_cnt + BIT_ONE;
            end else if (fall && r.bit_cnt == BITS_PER_BYTE) begin
               s.bit_cnt = 4'h0;
               case (r.state)
                  ST_ADDR: begin
                     if (r.shift[7:1] == DEV_ADDR) begin
                        s.rw = r.shift[0];
                        s.sda_oe = 1'b1;
                        s.state = ST_ADDR_ACK;
                     end else begin
                        s.state = ST_IDLE;
                     end
                  end
                  ST_CMD: begin
                     s.idx = r.shift;
                     s.sda_oe = 1'b1;
                     s.state = ST_CMD_ACK;
                  end
                  ST_CNT: begin
                     s.wr_left = r.shift;
                     s.sda_oe = 1'b1;
                     s.state = ST_CNT_ACK;
                  end
                  ST_WDATA: begin
                     // bytes past the announced count are refused with a nack
                     if (r.wr_left != 8'h00) begin
                        s.idx = r.idx + IDX_ONE;
                        s.wr_left = r.wr_left - 8'h01;
                        s.sda_oe = 1'b1;
                        s.state = ST_WDATA_ACK;
                     end else begin
                        s.state = ST_IDLE;
                     end
                  end
                  default: s.state = ST_IDLE;
               endcase
            end
         end
         ST_ADDR_ACK: begin
            if (fall) begin
               s.bit_cnt = 4'h0;
               if (r.rw) begin
                  // length byte goes out first in a block read
                  s.shift = {3'h0, len_byte[LEN_MSB:0]};
                  s.sda_oe = 1'b1;
                  s.state = ST_RDATA;
               end else begin
                  s.sda_oe = 1'b0;
                  s.state = ST_CMD;
               end
            end
         end
         ST_CMD_ACK: begin
            if (fall) begin
               s.sda_oe = 1'b0;
               s.state = ST_CNT;
            end
         end
         ST_CNT_ACK, ST_WDATA_ACK: begin
            if (fall) begin
               s.sda_oe = 1'b0;
               s.state = ST_WDATA;
            end
         end
         ST_RDATA: begin
            if (rise) begin
               s.bit_cnt = r.bit_cnt + BIT_ONE;
            end else if (fall) begin
               if (r.bit_cnt == BITS_PER_BYTE) begin
                  s.bit_cnt = 4'h0;
                  s.sda_oe = 1'b0;
                  s.acked = 1'b0;
                  s.state = ST_RD_ACK;
               end else begin
                  s.shift = {r.shift[6:0], 1'b0};
                  s.sda_oe = ~r.shift[6];
               end
            end else if (r.bit_cnt == 4'h0) begin
               // open drain: pull low only for a zero bit
               s.sda_oe = ~r.shift[7];
            end
         end
         ST_RD_ACK: begin
            if (rise) begin
               s.acked = ~sda_in;
            end else if (fall) begin
               if (r.acked) begin
                  s.shift = rd_data;
                  s.idx = r.idx + IDX_ONE;
                  s.sda_oe = ~rd_data[7];
                  s.state = ST_RDATA;
               end else begin
                  s.state = ST_IDLE;
               end
            end
         end
         default: begin
            s.state = ST_IDLE;
            s.sda_oe = 1'b0;
         end
      endcase

      // framing conditions override any byte in progress
      if (start_cond) begin
         s.state = ST_ADDR;
         s.bit_cnt = 4'h0;
         s.sda_oe = 1'b0;
      end else if (stop_cond) begin
         s.state = ST_IDLE;
         s.bit_cnt = 4'h0;
         s.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{state: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00, idx: 8'h00, rw: 1'b0,
                wr_left: 8'h00, acked: 1'b0, scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0,
                sda_out: 1'b0, freq_op: FREQ_100, slew: RST_FREQ[SLEW_BIT],
                fbimp: IMP_RST, oimp: RST_OIMP, run: '0, tl: '0, cl: '0, hz: '0};
      end else begin
         r <= s;
      end
   end

   assign sda_out = r.sda_out;
   assign sda_oe = r.sda_oe;
   assign operating_freq = r.freq_op;
   assign feedback_edge_speed_select = r.slew;
   assign feedback_impedance_code = r.fbimp;
   assign output_impedance_codes = r.oimp;
   assign dif_running = r.run;
   assign dif_true_high = r.tl;
   assign dif_comp_high = r.cl;
   assign dif_hiz = r.hz;
endmodule

// ===== shared/cbr_pkg.sv
// shared constants and types for the clock buffer configuration register slice
package cbr_pkg;

   // register indices on the management bus
   localparam logic [7:0] IDX_FREQ = 8'h03;
   localparam logic [7:0] IDX_RSV4 = 8'h04;
   localparam logic [7:0] IDX_REVMAK = 8'h05;
   localparam logic [7:0] IDX_PART = 8'h06;
   localparam logic [7:0] IDX_LEN = 8'h07;
   localparam logic [7:0] IDX_RSV8 = 8'h08;
   localparam logic [7:0] IDX_RSV9 = 8'h09;
   localparam logic [7:0] IDX_PD = 8'h0a;
   localparam logic [7:0] IDX_FBIMP = 8'h0b;
   localparam logic [7:0] IDX_OIMP = 8'h0c;
   localparam logic [7:0] IDX_ONE = 8'h01;

   // writable bits per register; all others are read-only or reserved
   localparam logic [7:0] WMASK_FREQ = 8'h39;
   localparam logic [7:0] WMASK_PART = 8'hff;
   localparam logic [7:0] WMASK_LEN = 8'h1f;
   localparam logic [7:0] WMASK_PD = 8'h40;
   localparam logic [7:0] WMASK_FBIMP = 8'hc3;
   localparam logic [7:0] WMASK_OIMP = 8'hff;

   // field positions
   localparam int FREQ_EN_BIT = 5;
   localparam int FREQ_CODE_LSB = 3;
   localparam int SLEW_BIT = 0;
   localparam int KEEP_BIT = 6;
   localparam int FBIMP_LSB = 6;
   localparam int DSTATE_LSB = 0;
   localparam int LEN_MSB = 4;

   // identification values: arbitrary neutral values
   localparam logic [3:0] REV_CODE = 4'h3;
   localparam logic [3:0] MAKER_CODE = 4'h5;
   localparam logic [1:0] PART_TYPE_RST = 2'h2;
   localparam logic [5:0] PART_ID_RST = 6'h15;

   // variant-dependent impedance reset code
   localparam logic [1:0] IMP_RST = 2'h2;

   // reset values
   localparam logic [7:0] RST_FREQ = 8'hc7;
   localparam logic [7:0] RST_PART = {PART_TYPE_RST, PART_ID_RST};
   localparam logic [7:0] RST_LEN = 8'h08;
   localparam logic [7:0] RST_PD = 8'h80;
   localparam logic [7:0] RST_FBIMP = {IMP_RST, 6'h00};
   localparam logic [7:0] RST_OIMP = {IMP_RST, IMP_RST, IMP_RST, IMP_RST};
   localparam logic [7:0] RSVD_READ = 8'h00;

   // frequency codes
   localparam logic [1:0] FREQ_100 = 2'h0;
   localparam logic [1:0] FREQ_50 = 2'h1;
   localparam logic [1:0] FREQ_125 = 2'h2;
   localparam logic [1:0] FREQ_RSVD = 2'h3;

   // disabled-output state codes (true/complement)
   localparam logic [1:0] DS_LOWLOW = 2'h0;
   localparam logic [1:0] DS_HIZ = 2'h1;
   localparam logic [1:0] DS_HIGHLOW = 2'h2;
   localparam logic [1:0] DS_LOWHIGH = 2'h3;

   // bus constants
   localparam logic [6:0] DEV_ADDR = 7'h6b;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam int NUM_OUT = 8;

   typedef enum logic [10:0] {
      ST_IDLE      = 11'h001,
      ST_ADDR      = 11'h002,
      ST_ADDR_ACK  = 11'h004,
      ST_CMD       = 11'h008,
      ST_CMD_ACK   = 11'h010,
      ST_CNT       = 11'h020,
      ST_CNT_ACK   = 11'h040,
      ST_WDATA     = 11'h080,
      ST_WDATA_ACK = 11'h100,
      ST_RDATA     = 11'h200,
      ST_RD_ACK    = 11'h400
   } cbr_state_type;

endpackage

// ===== verification/cbr_checker.sv
// port assertions for the configuration register slice
`timescale 1ns/100ps
module cbr_checker (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic pwr_down,
   input wire logic [cbr_pkg::NUM_OUT-1:0] out_enable_bits,
   input wire logic [cbr_pkg::NUM_OUT-1:0] oe_pin_active,
   input wire logic [1:0] operating_freq,
   input wire logic feedback_edge_speed_select,
   input wire logic [1:0] feedback_impedance_code,
   input wire logic [7:0] output_impedance_codes,
   input wire logic [cbr_pkg::NUM_OUT-1:0] dif_running,
   input wire logic [cbr_pkg::NUM_OUT-1:0] dif_true_high,
   input wire logic [cbr_pkg::NUM_OUT-1:0] dif_comp_high,
   input wire logic [cbr_pkg::NUM_OUT-1:0] dif_hiz
);
   import cbr_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // the first edge after release still sees inputs sampled in reset
   run_follow_a:
      assert property ($past(rstn) |-> dif_running == $past(out_enable_bits & oe_pin_active))
      else $error("running mask wrong");
   dis_state_a:
      assert property (((dif_running & (dif_true_high | dif_comp_high | dif_hiz))
         | (dif_true_high & (dif_comp_high | dif_hiz)) | (dif_comp_high & dif_hiz)) == '0)
      else $error("output state clash");
   hiz_same_a:
      assert property ((dif_hiz & ~dif_running) == '0 || (dif_hiz | dif_running) == '1)
      else $error("disabled outputs differ in hiz");
   high_same_a:
      assert property (((dif_true_high & ~dif_running) == '0 || (dif_true_high | dif_running) == '1)
         && ((dif_comp_high & ~dif_running) == '0 || (dif_comp_high | dif_running) == '1))
      else $error("disabled outputs differ in level");
   freq_legal_a:
      assert property (operating_freq != FREQ_RSVD) else $error("reserved frequency used");
   // an idle bus with power up carries no write, so frequency, slew and impedance outputs may not move
   config_quiet_a:
      assert property ((scl_in && sda_in && !pwr_down)[*8] |-> $stable(operating_freq)
         && $stable(output_impedance_codes) && $stable(feedback_impedance_code)
         && $stable(feedback_edge_speed_select)) else $error("config moved on idle bus");
   ack_timing_a:
      assert property ($changed(sda_oe) |-> !$past(scl_in)) else $error("data moved with clock high");
   open_drain_a:
      assert property (sda_oe |-> !sda_out) else $error("data line driven high");
endmodule
bind cbr_top cbr_checker chk_i (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .pwr_down(pwr_down), .out_enable_bits(out_enable_bits),
   .oe_pin_active(oe_pin_active), .operating_freq(operating_freq),
   .feedback_edge_speed_select(feedback_edge_speed_select),
   .feedback_impedance_code(feedback_impedance_code),
   .output_impedance_codes(output_impedance_codes), .dif_running(dif_running),
   .dif_true_high(dif_true_high), .dif_comp_high(dif_comp_high), .dif_hiz(dif_hiz));

// ===== verification/cbr_host.sv
// management bus host model, open drain data, clock still between frames
`timescale 1ns/100ps
module cbr_host (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick();
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic bit_out(input logic b);
      sda_drv <= b;
      tick();
      scl <= 1'b1;
      tick();
      scl <= 1'b0;
   endtask
   // sample mid cycle so the registered data line has settled
   task automatic bit_in(output logic b);
      sda_drv <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      @(negedge sys_clk);
      b = sda;
      @(posedge sys_clk);
      scl <= 1'b0;
   endtask
   task automatic start();
      sda_drv <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      sda_drv <= 1'b0;
      tick();
      scl <= 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_drv <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
      sda_drv <= 1'b1;
      tick();
   endtask
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(a);
      ack = !a;
   endtask
   task automatic byte_in(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(!ack);
   endtask
endmodule

// ===== verification/cbr_top_test.sv
// self-checking bench for the configuration register slice
`timescale 1ns/100ps
module cbr_top_test;
   import cbr_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic pwr_down = 1'b0;
   logic [7:0] oe_bits = 8'hff;
   logic [7:0] pin_act = 8'hff;
   logic [7:0] len_seen, exp_f, out_imp, run, t_hi, c_hi, hiz;
   logic [7:0] got [0:15];
   logic scl, sda_drv, sda_out, sda_oe, slew, ack;
   logic [1:0] op_freq, fb_imp;
   int error_cnt = 0;
   int checked = 0;
   logic [7:0] rst_exp [0:9] = '{8'hc7, 8'h00, {REV_CODE, MAKER_CODE}, RST_PART, 8'h08,
      8'h00, 8'h00, 8'h80, {IMP_RST, 6'h00}, {4{IMP_RST}}};
   // index, written byte, byte read back
   logic [23:0] rows [0:10] = '{24'h0300c6, 24'h04ff00, {IDX_REVMAK, 8'h00, REV_CODE, MAKER_CODE},
      24'h063c3c, 24'h07ff1f, 24'h08ff00, 24'h09a500, 24'h0affc0, 24'h0bffc3, 24'h0c1b1b,
      24'h0dff00};
   wire sda = sda_drv & (sda_oe ? sda_out : 1'b1);
   always #4 sys_clk = ~sys_clk;
   cbr_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
   cbr_top dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .pwr_down(pwr_down), .out_enable_bits(oe_bits), .oe_pin_active(pin_act),
      .operating_freq(op_freq), .feedback_edge_speed_select(slew),
      .feedback_impedance_code(fb_imp), .output_impedance_codes(out_imp), .dif_running(run),
      .dif_true_high(t_hi), .dif_comp_high(c_hi), .dif_hiz(hiz));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic put(input logic [7:0] d);
      logic a;
      host.byte_out(d, a);
      chk({7'h00, a}, 8'h01);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host.start();
      put({DEV_ADDR, 1'b0});
      put(idx);
      put(8'h01);
      put(d);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] idx, input int n);
      host.start();
      put({DEV_ADDR, 1'b0});
      put(idx);
      host.start();
      put({DEV_ADDR, 1'b1});
      host.byte_in(1'b1, len_seen);
      for (int i = 0; i < n; i++) host.byte_in(i < n - 1, got[i]);
      host.stop();
   endtask
   task automatic pulse_pd();
      pwr_down <= 1'b1;
      repeat (4) @(posedge sys_clk);
      pwr_down <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // the host tasks have fixed lengths, so only a global limit is needed
   initial begin
      repeat (100000) @(posedge sys_clk);
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({6'h00, op_freq}, {6'h00, FREQ_100});
      chk({7'h00, slew}, 8'h01);
      chk({6'h00, fb_imp}, {6'h00, IMP_RST});
      chk(out_imp, {4{IMP_RST}});
      @(posedge sys_clk);
      rd(IDX_FREQ, 10);
      chk(len_seen, 8'h08);
      for (int i = 0; i < 10; i++) chk(got[i], rst_exp[i]);
      $display("reset test done");
      for (int i = 0; i < 11; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], 1);
         chk(got[0], rows[i][7:0]);
      end
      chk({7'h00, slew}, 8'h00);
      chk({6'h00, fb_imp}, 8'h03);
      chk(out_imp, 8'h1b);
      $display("table test done");
      wr(IDX_FREQ, 8'h10);
      chk({6'h00, op_freq}, {6'h00, FREQ_100});
      exp_f = {6'h00, FREQ_100};
      for (int c = 1; c < 5; c++) begin
         wr(IDX_FREQ, {2'h0, 1'b1, c[1:0], 3'h0});
         if (c[1:0] != FREQ_RSVD) exp_f = {6'h00, c[1:0]};
         chk({6'h00, op_freq}, exp_f);
      end
      $display("frequency test done");
      oe_bits <= 8'h0f;
      pin_act <= 8'h7e;
      for (int d = 0; d < 4; d++) begin
         wr(IDX_FBIMP, {6'h20, d[1:0]});
         @(negedge sys_clk);
         chk(run, 8'h0e);
         chk(hiz, (d == 1) ? 8'hf1 : 8'h00);
         chk(t_hi, (d == 2) ? 8'hf1 : 8'h00);
         chk(c_hi, (d == 3) ? 8'hf1 : 8'h00);
         @(posedge sys_clk);
      end
      $display("disable state test done");
      pulse_pd();
      rd(IDX_OIMP, 1);
      chk(got[0], 8'h1b);
      wr(IDX_PD, 8'h00);
      pulse_pd();
      rd(IDX_FREQ, 10);
      for (int i = 0; i < 10; i++) chk(got[i], rst_exp[i]);
      chk(out_imp, {4{IMP_RST}});
      $display("power down test done");
      // a byte beyond the announced count must be refused and must not land
      host.start();
      put({DEV_ADDR, 1'b0});
      put(IDX_FBIMP);
      put(8'h01);
      put(8'h41);
      host.byte_out(8'h5a, ack);
      host.stop();
      chk({7'h00, ack}, 8'h00);
      rd(IDX_FBIMP, 2);
      chk(got[0], 8'h41);
      chk(got[1], {4{IMP_RST}});
      host.start();
      put({DEV_ADDR, 1'b0});
      put(IDX_FBIMP);
      put(8'h02);
      put(8'hbe);
      put(8'h1b);
      host.stop();
      rd(IDX_FBIMP, 2);
      chk(got[0], 8'h82);
      chk(got[1], 8'h1b);
      $display("block write test done");
      host.start();
      host.byte_out({DEV_ADDR ^ 7'h01, 1'b0}, ack);
      host.stop();
      chk({7'h00, ack}, 8'h00);
      rstn <= 1'b0;
      @(negedge sys_clk);
      chk(run, 8'h00);
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(run, 8'h0e);
      chk(out_imp, {4{IMP_RST}});
      chk({6'h00, fb_imp}, {6'h00, IMP_RST});
      @(posedge sys_clk);
      // bytes 0x0b and 0x0c were changed above, so the reset is visible here
      rd(IDX_FREQ, 10);
      for (int i = 0; i < 10; i++) chk(got[i], rst_exp[i]);
      $display("refusal and reset test done");
      final_report();
   end
endmodule
